// [hw/pulse_axis.sv]
`timescale 1ns/100ps
module pulse_axis
  import motion_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // command side
  axis_link_if.axis lnk
);
  // ****************************************
  // state
  // ****************************************
  logic running_q;
  logic dir_q;
  logic pulse_q;
  move_mode_type mode_q;
  logic [SPEED_W-1:0] speed_q;
  logic [SPEED_W-1:0] target_q;
  logic [SPEED_W-1:0] accel_ext;
  logic [COUNT_W-1:0] remain_q;
  logic [PERIOD_W-1:0] acc_q;
  logic [PERIOD_W:0] acc_sum;
  logic [PERIOD_W:0] acc_wrap;
  logic pulse_d;
  logic launch;
  logic count_done;
  logic home_done;
  logic slow_done;

  // rate generator: speed pulses spread over one profile period
  assign acc_sum = {1'b0, acc_q} + {{(PERIOD_W+1-SPEED_W){1'b0}}, speed_q};
  assign acc_wrap = acc_sum - {1'b0, lnk.period_len};
  assign pulse_d = running_q && (acc_sum >= {1'b0, lnk.period_len});
  assign accel_ext = {{(SPEED_W-ACC_W){1'b0}}, lnk.accel};
  // a zero count move never starts; change-speed from rest starts a run
  assign launch = (lnk.start && !(lnk.mode == MODE_COUNT && lnk.count == '0))
    || (lnk.change && !running_q);
  assign count_done = mode_q == MODE_COUNT && pulse_d && remain_q == COUNT_LAST;
  // origin checked per update, so latency tracks the period
  assign home_done = mode_q == MODE_HOME && lnk.tick && lnk.home_hit;
  assign slow_done = target_q == '0 && speed_q == '0;

  // run flag; a stop beats any start in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      running_q <= 1'b0;
    end else if (lnk.stop) begin
      running_q <= 1'b0;
    end else if (launch) begin
      running_q <= 1'b1;
    end else if (count_done || home_done || slow_done) begin
      running_q <= 1'b0;
    end
  end

  // mode and direction latch only from rest
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mode_q <= MODE_RUN;
      dir_q <= DIR_CW;
    end else if (launch) begin
      mode_q <= lnk.change ? MODE_RUN : lnk.mode;
      dir_q <= lnk.dir;
    end
  end

  // target speed; repeated changes are taken while moving
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      target_q <= '0;
    end else if (launch || lnk.change) begin
      target_q <= lnk.speed;
    end else if (lnk.slow_stop) begin
      target_q <= '0;
    end
  end

  // speed ramps by the accel step once per profile update
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      speed_q <= '0;
    end else if (launch) begin
      speed_q <= (lnk.speed < lnk.low_speed) ? lnk.speed : lnk.low_speed;
    end else if (!running_q) begin
      speed_q <= '0;
    end else if (lnk.tick) begin
      if (speed_q < target_q) begin
        speed_q <= (target_q - speed_q > accel_ext) ?
          speed_q + accel_ext : target_q;
      end else if (speed_q > target_q) begin
        speed_q <= (speed_q - target_q > accel_ext) ?
          speed_q - accel_ext : target_q;
      end
    end
  end

  // remaining pulses of a count move
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      remain_q <= '0;
    end else if (launch) begin
      remain_q <= lnk.count;
    end else if (pulse_d && mode_q == MODE_COUNT) begin
      remain_q <= remain_q - COUNT_LAST;
    end
  end

  // phase accumulator and registered pulse
  always_ff @(posedge core_clk_i) begin
    if (rst_i || launch || !running_q) begin
      acc_q <= '0;
    end else begin
      acc_q <= pulse_d ? acc_wrap[PERIOD_W-1:0] : acc_sum[PERIOD_W-1:0];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= pulse_d;
    end
  end

  assign lnk.running = running_q;
  assign lnk.pulse = pulse_q;
  assign lnk.dir_out = dir_q;

  // ****************************************
  // checks
  // ****************************************
  property p_home_stop;
    @(posedge core_clk_i) disable iff (rst_i)
    running_q && home_done && !lnk.start |=> !running_q;
  endproperty
  a_home_stop: assert property (p_home_stop)
    else $error("axis kept running after origin reached");

  property p_count_step;
    @(posedge core_clk_i) disable iff (rst_i)
    running_q && mode_q == MODE_COUNT && pulse_d && !launch
      |=> remain_q == $past(remain_q) - COUNT_LAST;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("pulse count not decremented");

  property p_count_end;
    @(posedge core_clk_i) disable iff (rst_i)
    running_q && count_done && !lnk.stop |=> !running_q && pulse_q;
  endproperty
  a_count_end: assert property (p_count_end)
    else $error("count move did not end on last pulse");

  property p_dir_hold;
    @(posedge core_clk_i) disable iff (rst_i)
    running_q |=> $stable(lnk.dir_out);
  endproperty
  a_dir_hold: assert property (p_dir_hold)
    else $error("direction changed while moving");

  property p_ramp_up;
    @(posedge core_clk_i) disable iff (rst_i)
    running_q && lnk.tick && speed_q < target_q && !lnk.change
      && !lnk.slow_stop && !lnk.stop
      |=> speed_q > $past(speed_q) && speed_q <= $past(target_q);
  endproperty
  a_ramp_up: assert property (p_ramp_up)
    else $error("speed did not ramp toward target");

  property p_run_holds;
    @(posedge core_clk_i) disable iff (rst_i)
    running_q && mode_q == MODE_RUN && target_q != '0 && !lnk.stop
      |=> running_q;
  endproperty
  a_run_holds: assert property (p_run_holds)
    else $error("continuous run ended without a stop");
endmodule : pulse_axis

// [hw/two_axis_motion_command_unit.sv]
`timescale 1ns/100ps
module two_axis_motion_command_unit
  import motion_pkg::*;
#(
  parameter int TICK_CYCLES = BASE_TICK_CYCLES,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // command port
  input wire logic cmd_valid_i,
  input wire cmd_op_type cmd_op_i,
  input wire logic [1:0] cmd_axis_i,
  input wire logic cmd_dir_i,
  input wire logic [COUNT_W-1:0] cmd_count_i,
  input wire logic [SPEED_W-1:0] cmd_speed_i,
  output logic cmd_ready_o,
  // motion configuration
  input wire logic [SET_W-1:0] profile_period_setting_i,
  input wire logic [ACC_W-1:0] accel_step_i,
  input wire logic [SPEED_W-1:0] low_speed_i,
  input wire logic [SPEED_W-1:0] high_speed_i,
  // machine switches, active high
  input wire logic [1:0] origin_switch_inputs_i,
  // motor drive
  output logic [1:0] pulse_o,
  output logic [1:0] dir_o,
  // status
  output logic first_axis_stopped_flag_o,
  output logic second_axis_stopped_flag_o,
  output logic fifo_empty_o,
  output logic fifo_full_o
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = PTR_W + 1;
  localparam int TICK_W = $clog2(TICK_CYCLES + 1);

  // ****************************************
  // helpers
  // ****************************************
  // axis code per lane
  function automatic logic [1:0] axis_code(input int idx);
    axis_code = (idx == 0) ? AXIS_SEL_X : AXIS_SEL_Y;
  endfunction : axis_code

  function automatic move_mode_type mode_of(input cmd_op_type op);
    case (op)
      OP_HOME_LOW, OP_HOME_HIGH: mode_of = MODE_HOME;
      OP_MOVE_LOW, OP_MOVE_HIGH, OP_MOVE_NORM: mode_of = MODE_COUNT;
      default: mode_of = MODE_RUN;
    endcase
  endfunction : mode_of

  // host keeps normal and change speeds legal, so they pass unchecked
  function automatic logic [SPEED_W-1:0] speed_of(input cmd_op_type op,
      input logic [SPEED_W-1:0] given, input logic [SPEED_W-1:0] lo,
      input logic [SPEED_W-1:0] hi);
    case (op)
      OP_HOME_LOW, OP_MOVE_LOW, OP_RUN_LOW: speed_of = lo;
      OP_HOME_HIGH, OP_MOVE_HIGH, OP_RUN_HIGH: speed_of = hi;
      default: speed_of = given;
    endcase
  endfunction : speed_of

  // ****************************************
  // origin switch synchronisers
  // ****************************************
  logic [1:0] org_s1_q;
  logic [1:0] org_s2_q;
  logic [1:0] org_s3_q;
  logic [1:0] org_q;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      org_s1_q <= '0;
      org_s2_q <= '0;
      org_s3_q <= '0;
    end else begin
      org_s1_q <= origin_switch_inputs_i;
      org_s2_q <= org_s1_q;
      org_s3_q <= org_s2_q;
    end
  end

  // level moves only when stages two and three agree
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      org_q <= '0;
    end else begin
      org_q <= (org_s2_q & org_s3_q) | (org_q & (org_s2_q | org_s3_q));
    end
  end

  // ****************************************
  // profile period divider
  // ****************************************
  logic [TICK_W-1:0] tick_cnt_q;
  logic [SET_W-1:0] per_cnt_q;
  logic [SET_W-1:0] setting_q;
  logic [PERIOD_W-1:0] period_len_q;
  logic base_tick;
  logic update_tick;

  assign base_tick = tick_cnt_q == TICK_W'(TICK_CYCLES - 1);
  // one update per setting plus one ticks
  assign update_tick = base_tick && per_cnt_q == setting_q;

  always_ff @(posedge core_clk_i) begin
    if (rst_i || base_tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i || update_tick) begin
      per_cnt_q <= '0;
    end else if (base_tick) begin
      per_cnt_q <= per_cnt_q + 1'b1;
    end
  end

  // setting taken at period boundaries so a period is never torn
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      setting_q <= SETTING_RESET;
      period_len_q <= PERIOD_W'((int'(SETTING_RESET) + 1) * TICK_CYCLES);
    end else if (update_tick) begin
      setting_q <= profile_period_setting_i;
      period_len_q <=
        PERIOD_W'((int'(profile_period_setting_i) + 1) * TICK_CYCLES);
    end
  end

  // ****************************************
  // command queue
  // ****************************************
  cmd_entry_type mem_q [DEPTH];
  cmd_entry_type head;
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [CNT_W-1:0] count_q;
  logic [1:0] running;
  logic is_stop;
  logic take;
  logic push;
  logic pop;
  logic stop_all;
  logic stop_x;
  logic stop_y;
  logic immediate;
  logic axis_free;
  logic head_legal;
  logic [COUNT_W-1:0] head_mag;
  logic head_dir;

  // stops bypass the queue, so they are taken even when it is full
  assign is_stop = cmd_op_i == OP_STOP_X || cmd_op_i == OP_STOP_Y
    || cmd_op_i == OP_STOP_ALL;
  assign fifo_full_o = count_q == CNT_W'(DEPTH);
  assign fifo_empty_o = count_q == '0;
  assign cmd_ready_o = is_stop || !fifo_full_o;
  assign take = cmd_valid_i && cmd_ready_o;
  assign push = take && !is_stop;
  assign stop_all = take && cmd_op_i == OP_STOP_ALL;
  assign stop_x = stop_all || (take && cmd_op_i == OP_STOP_X);
  assign stop_y = stop_all || (take && cmd_op_i == OP_STOP_Y);

  assign head = mem_q[rd_ptr_q];
  assign head_legal = head.axis == AXIS_SEL_X || head.axis == AXIS_SEL_Y;
  assign immediate = head.op == OP_CHANGE_SPEED || head.op == OP_SLOW_STOP;
  assign axis_free = (head.axis == AXIS_SEL_Y) ? !running[1] : !running[0];
  // moves wait for their axis to rest; a bad axis code is dropped
  assign pop = !fifo_empty_o && !stop_x && !stop_y
    && (!head_legal || immediate || axis_free);

  assign head_mag = head.count[COUNT_W-1] ? -head.count : head.count;
  assign head_dir = (mode_of(head.op) == MODE_COUNT) ?
    (head.count[COUNT_W-1] ? DIR_CCW : DIR_CW) : head.dir;

  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= '{cmd_op_i, cmd_axis_i, cmd_dir_i, cmd_count_i,
        cmd_speed_i};
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i || stop_all) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_q + PTR_W'(push);
      rd_ptr_q <= rd_ptr_q + PTR_W'(pop);
      count_q <= count_q + CNT_W'(push) - CNT_W'(pop);
    end
  end

  // ****************************************
  // axis lanes
  // ****************************************
  axis_link_if lnk [2] ();

  for (genvar i = 0; i < 2; i++) begin : g_axis
    logic hit;
    assign hit = pop && head.axis == axis_code(i);
    assign lnk[i].tick = update_tick;
    assign lnk[i].start = hit && !immediate;
    assign lnk[i].change = hit && head.op == OP_CHANGE_SPEED;
    assign lnk[i].slow_stop = hit && head.op == OP_SLOW_STOP;
    assign lnk[i].stop = (i == 0) ? stop_x : stop_y;
    assign lnk[i].home_hit = org_q[i];
    assign lnk[i].dir = head_dir;
    assign lnk[i].mode = mode_of(head.op);
    assign lnk[i].speed = speed_of(head.op, head.speed, low_speed_i,
      high_speed_i);
    assign lnk[i].low_speed = low_speed_i;
    assign lnk[i].accel = accel_step_i;
    assign lnk[i].count = head_mag;
    assign lnk[i].period_len = period_len_q;
    assign running[i] = lnk[i].running;
    assign pulse_o[i] = lnk[i].pulse;
    assign dir_o[i] = lnk[i].dir_out;
    pulse_axis u_axis (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .lnk(lnk[i])
    );
  end

  assign first_axis_stopped_flag_o = !running[0];
  assign second_axis_stopped_flag_o = !running[1];

  // ****************************************
  // checks
  // ****************************************
  logic [PERIOD_W-1:0] gap_q;
  logic gap_seen_q;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      gap_q <= '0;
      gap_seen_q <= 1'b0;
    end else if (update_tick) begin
      gap_q <= '0;
      gap_seen_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 1'b1;
    end
  end

  sequence s_stop_all_taken;
    cmd_valid_i && cmd_ready_o && cmd_op_i == OP_STOP_ALL;
  endsequence
  sequence s_both_halted;
    first_axis_stopped_flag_o && second_axis_stopped_flag_o && fifo_empty_o;
  endsequence

  property p_stop_all;
    @(posedge core_clk_i) disable iff (rst_i)
    s_stop_all_taken |=> s_both_halted;
  endproperty
  a_stop_all: assert property (p_stop_all)
    else $error("stop-both left motion or queued commands");

  property p_stop_one;
    @(posedge core_clk_i) disable iff (rst_i)
    take && cmd_op_i == OP_STOP_X |=> first_axis_stopped_flag_o;
  endproperty
  a_stop_one: assert property (p_stop_one)
    else $error("first axis did not halt on its stop");

  property p_axis_sel;
    @(posedge core_clk_i) disable iff (rst_i)
    pop && head.axis == AXIS_SEL_Y
      |-> !lnk[0].start && !lnk[0].change && lnk[1].start == !immediate;
  endproperty
  a_axis_sel: assert property (p_axis_sel)
    else $error("command routed to the wrong axis");

  property p_period;
    @(posedge core_clk_i) disable iff (rst_i)
    update_tick && gap_seen_q |-> gap_q == period_len_q - 1'b1;
  endproperty
  a_period: assert property (p_period)
    else $error("profile update period length wrong");
endmodule : two_axis_motion_command_unit

// [shared/axis_link_if.sv]
`timescale 1ns/100ps
interface axis_link_if;
  import motion_pkg::*;
  logic tick;
  logic start;
  logic stop;
  logic change;
  logic slow_stop;
  logic home_hit;
  logic dir;
  move_mode_type mode;
  logic [SPEED_W-1:0] speed;
  logic [SPEED_W-1:0] low_speed;
  logic [ACC_W-1:0] accel;
  logic [COUNT_W-1:0] count;
  logic [PERIOD_W-1:0] period_len;
  logic running;
  logic pulse;
  logic dir_out;
  modport ctrl (
    output tick, start, stop, change, slow_stop, home_hit, dir, mode,
    output speed, low_speed, accel, count, period_len,
    input running, pulse, dir_out
  );
  modport axis (
    input tick, start, stop, change, slow_stop, home_hit, dir, mode,
    input speed, low_speed, accel, count, period_len,
    output running, pulse, dir_out
  );
endinterface : axis_link_if

// [shared/motion_pkg.sv]
package motion_pkg;
  // ****************************************
  // widths and limits
  // ****************************************
  localparam int SPEED_W = 12;
  localparam int ACC_W = 8;
  localparam int COUNT_W = 20;
  localparam int SET_W = 8;
  localparam int PERIOD_W = 24;
  localparam int FIFO_DEPTH = 8;
  localparam logic [COUNT_W-1:0] COUNT_LAST = 20'h0_0001;
  localparam logic [SET_W-1:0] SETTING_RESET = 8'h0A;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int BASE_TICK_NS = 1_024_000;
  localparam int BASE_TICK_CYCLES = BASE_TICK_NS / CLK_PERIOD_NS;

  // ****************************************
  // argument encodings
  // ****************************************
  localparam logic [1:0] AXIS_SEL_X = 2'h1;
  localparam logic [1:0] AXIS_SEL_Y = 2'h2;
  localparam logic DIR_CW = 1'b0;
  localparam logic DIR_CCW = 1'b1;

  typedef enum logic [3:0] {
    OP_STOP_X, OP_STOP_Y, OP_STOP_ALL, OP_HOME_LOW, OP_HOME_HIGH,
    OP_MOVE_LOW, OP_MOVE_HIGH, OP_MOVE_NORM, OP_RUN_LOW, OP_RUN_HIGH,
    OP_CHANGE_SPEED, OP_SLOW_STOP
  } cmd_op_type;

  typedef enum logic [1:0] {MODE_COUNT, MODE_RUN, MODE_HOME} move_mode_type;

  typedef struct packed {
    cmd_op_type op;
    logic [1:0] axis;
    logic dir;
    logic [COUNT_W-1:0] count;
    logic [SPEED_W-1:0] speed;
  } cmd_entry_type;
endpackage : motion_pkg

// [tb/host_model.sv]
`timescale 1ns/100ps
// ****************************************
// host side of the command port
// ****************************************
module host_model
  import motion_pkg::*;
(
  // clock
  input wire logic core_clk_i,
  // command port toward the unit
  output logic cmd_valid_o,
  output cmd_op_type cmd_op_o,
  output logic [1:0] cmd_axis_o,
  output logic cmd_dir_o,
  output logic [COUNT_W-1:0] cmd_count_o,
  output logic [SPEED_W-1:0] cmd_speed_o,
  input wire logic cmd_ready_i,
  // speed band the host configured
  input wire logic [SPEED_W-1:0] low_speed_i,
  input wire logic [SPEED_W-1:0] high_speed_i
);
  // quiet port until the first command
  initial begin
    cmd_valid_o = 1'b0;
    cmd_op_o = OP_STOP_X;
    cmd_axis_o = AXIS_SEL_X;
    cmd_dir_o = DIR_CW;
    cmd_count_o = '0;
    cmd_speed_o = '0;
  end

  // held until an edge sees ready; an idle cycle follows each command
  task automatic send(input cmd_op_type op, input logic [1:0] axis,
      input logic dir, input logic [COUNT_W-1:0] count,
      input logic [SPEED_W-1:0] speed);
    logic rdy;
    @(posedge core_clk_i);
    #1;
    if (op == OP_MOVE_NORM && speed < low_speed_i) speed = low_speed_i;
    if (op == OP_MOVE_NORM && speed > high_speed_i) speed = high_speed_i;
    if (op == OP_CHANGE_SPEED && speed == 12'h000) speed = 12'h001;
    if (op == OP_CHANGE_SPEED && speed > 12'h7F8) speed = 12'h7F8;
    cmd_op_o = op;
    cmd_axis_o = axis;
    cmd_dir_o = dir;
    cmd_count_o = count;
    cmd_speed_o = speed;
    cmd_valid_o = 1'b1;
    // ready is read mid-cycle, where it is settled for the coming edge
    do begin
      @(negedge core_clk_i);
      rdy = cmd_ready_i;
      @(posedge core_clk_i);
    end while (rdy !== 1'b1);
    #1;
    cmd_valid_o = 1'b0;
  endtask : send
endmodule : host_model

// [tb/testbench.sv]
`timescale 1ns/100ps
// ****************************************
// top of the bench
// ****************************************
module testbench;
  import motion_pkg::*;
  localparam int TICKS = 4;
  localparam cmd_op_type OPS[3] = '{OP_MOVE_LOW, OP_MOVE_HIGH, OP_MOVE_NORM};
  logic core_clk, rst, cmd_valid, cmd_dir, cmd_ready, neg;
  cmd_op_type cmd_op;
  logic [1:0] cmd_axis, origin, pulse, dir;
  logic [COUNT_W-1:0] cmd_count, cnt;
  logic [SPEED_W-1:0] cmd_speed, low, high, spd;
  logic [SET_W-1:0] setting;
  logic [ACC_W-1:0] accel;
  logic stop0, stop1, f_empty, f_full;
  int failures, samples_checked, seed, per, ax, mag;
  int pcnt[2], base[2];

  two_axis_motion_command_unit #(.TICK_CYCLES(TICKS), .DEPTH(FIFO_DEPTH))
      two_axis_motion_command_unit_i (.core_clk_i(core_clk), .rst_i(rst),
    .cmd_valid_i(cmd_valid), .cmd_op_i(cmd_op), .cmd_axis_i(cmd_axis),
    .cmd_dir_i(cmd_dir), .cmd_count_i(cmd_count), .cmd_speed_i(cmd_speed),
    .cmd_ready_o(cmd_ready), .profile_period_setting_i(setting),
    .accel_step_i(accel), .low_speed_i(low), .high_speed_i(high),
    .origin_switch_inputs_i(origin), .pulse_o(pulse), .dir_o(dir),
    .first_axis_stopped_flag_o(stop0), .second_axis_stopped_flag_o(stop1),
    .fifo_empty_o(f_empty), .fifo_full_o(f_full));

  host_model host_model_i (.core_clk_i(core_clk), .cmd_valid_o(cmd_valid),
    .cmd_op_o(cmd_op), .cmd_axis_o(cmd_axis), .cmd_dir_o(cmd_dir),
    .cmd_count_o(cmd_count), .cmd_speed_o(cmd_speed),
    .cmd_ready_i(cmd_ready), .low_speed_i(low), .high_speed_i(high));

  // 40 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // watchdog, well past the expected run length
  initial begin
    #(25 * 60000);
    failures++;
    stop_test();
  end

  // pulses counted mid-cycle, away from the edge that moves them
  always @(negedge core_clk) begin
    if (pulse[0] === 1'b1) pcnt[0]++;
    if (pulse[1] === 1'b1) pcnt[1]++;
  end

  task automatic check(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %0d seen %0d", name, exp, seen);
    end
  endtask : check

  task automatic mark();
    @(posedge core_clk);
    base = pcnt;
  endtask : mark

  function automatic int got(input int a);
    return pcnt[a] - base[a];
  endfunction : got

  function automatic logic flag(input int a);
    return a == 0 ? stop0 : stop1;
  endfunction : flag

  function automatic int exp_pulses(input logic [SPEED_W-1:0] s, input int p);
    return int'(s) * p;
  endfunction : exp_pulses

  task automatic wait_flag(input int a, input logic v, input int lim);
    int n;
    n = 0;
    @(negedge core_clk);
    while (flag(a) !== v && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    check("stopped flag", flag(a), v);
  endtask : wait_flag

  // rate over a window; slack of two covers window phase
  task automatic near(input string name, input int a, input int exp);
    @(posedge core_clk);
    check(name, got(a) + 2 >= exp && got(a) <= exp + 2, 1'b1);
  endtask : near

  task automatic stop_test();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  // main sequence
  initial begin
    seed = 81;
    rst = 1'b1;
    setting = 8'h04;
    accel = 8'h02;
    low = 12'h005;
    high = 12'h00F;
    origin = 2'h0;
    failures = 0;
    samples_checked = 0;
    per = (int'(setting) + 1) * TICKS;
    repeat (8) @(posedge core_clk);
    #1;
    rst = 1'b0;
    @(negedge core_clk);
    check("stopped x", stop0, 1'b1);
    check("stopped y", stop1, 1'b1);
    check("fifo empty", f_empty, 1'b1);
    check("fifo full", f_full, 1'b0);
    // count moves: random axis, sign and size; low, high and random normal speed in turn
    for (int i = 0; i < 12; i++) begin
      ax = $unsigned($random(seed)) % 2;
      mag = 1 + $unsigned($random(seed)) % 20;
      neg = 1'($random(seed));
      spd = low + 12'($unsigned($random(seed)) % (high - low + 1));
      cnt = neg ? COUNT_W'(-mag) : COUNT_W'(mag);
      mark();
      host_model_i.send(OPS[i % 3], ax ? AXIS_SEL_Y : AXIS_SEL_X,
        DIR_CW, cnt, spd);
      wait_flag(ax, 1'b0, 8);
      wait_flag(ax, 1'b1, 40 * per);
      repeat (2) @(negedge core_clk);
      check("direction", dir[ax], neg);
      @(posedge core_clk);
      check("pulses", got(ax), mag);
      check("other axis", got(1 - ax), 0);
    end
    // endless runs on both axes, then stop one
    host_model_i.send(OP_RUN_LOW, AXIS_SEL_X, DIR_CCW, '0, '0);
    host_model_i.send(OP_RUN_HIGH, AXIS_SEL_Y, DIR_CW, '0, '0);
    repeat (8 * per) @(negedge core_clk);
    mark();
    repeat (4 * per) @(negedge core_clk);
    near("low rate", 0, exp_pulses(low, 4));
    near("high rate", 1, exp_pulses(high, 4));
    check("dir x", dir[0], DIR_CCW);
    check("dir y", dir[1], DIR_CW);
    host_model_i.send(OP_STOP_X, AXIS_SEL_X, DIR_CW, '0, '0);
    @(negedge core_clk);
    check("x stopped", stop0, 1'b1);
    check("y running", stop1, 1'b0);
    // moves pile up behind the busy axis until the queue refuses
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      host_model_i.send(OP_MOVE_LOW, AXIS_SEL_Y, DIR_CW, 20'h0_0005, low);
    end
    @(negedge core_clk);
    check("full", f_full, 1'b1);
    check("refused", cmd_ready, 1'b0);
    host_model_i.send(OP_STOP_ALL, AXIS_SEL_X, DIR_CW, '0, '0);
    @(negedge core_clk);
    check("all x", stop0, 1'b1);
    check("all y", stop1, 1'b1);
    check("flushed", f_empty, 1'b1);
    mark();
    repeat (3 * per) @(negedge core_clk);
    @(posedge core_clk);
    check("quiet", got(0) + got(1), 0);
    // homing, low on the first axis and high on the second
    for (int i = 0; i < 2; i++) begin
      neg = 1'($random(seed));
      host_model_i.send(i ? OP_HOME_HIGH : OP_HOME_LOW,
        i ? AXIS_SEL_Y : AXIS_SEL_X, neg, '0, '0);
      wait_flag(i, 1'b0, 8);
      repeat (8 * per) @(negedge core_clk);
      mark();
      repeat (4 * per) @(negedge core_clk);
      near("home rate", i, exp_pulses(i ? high : low, 4));
      #1;
      check("homing", flag(i), 1'b0);
      check("home dir", dir[i], neg);
      origin[i] = 1'b1;
      wait_flag(i, 1'b1, per + 12);
      @(posedge core_clk);
      #1;
      origin[i] = 1'b0;
    end
    // speed changed twice while moving, then ramped down to rest
    spd = 12'h001 + 12'($unsigned($random(seed)) % high);
    host_model_i.send(OP_RUN_LOW, AXIS_SEL_X, DIR_CW, '0, '0);
    host_model_i.send(OP_CHANGE_SPEED, AXIS_SEL_X, DIR_CW, '0, high);
    host_model_i.send(OP_CHANGE_SPEED, AXIS_SEL_X, DIR_CW, '0, spd);
    repeat (10 * per) @(negedge core_clk);
    mark();
    repeat (4 * per) @(negedge core_clk);
    near("changed rate", 0, exp_pulses(spd, 4));
    host_model_i.send(OP_SLOW_STOP, AXIS_SEL_X, DIR_CW, '0, '0);
    wait_flag(0, 1'b1, 12 * per);
    // second axis stop spares the first; a bad axis code is dropped
    host_model_i.send(OP_RUN_LOW, AXIS_SEL_X, DIR_CW, '0, '0);
    host_model_i.send(OP_RUN_LOW, AXIS_SEL_Y, DIR_CW, '0, '0);
    host_model_i.send(OP_RUN_HIGH, 2'h3, DIR_CW, '0, '0);
    host_model_i.send(OP_STOP_Y, AXIS_SEL_Y, DIR_CW, '0, '0);
    @(negedge core_clk);
    check("y stopped", stop1, 1'b1);
    check("x kept", stop0, 1'b0);
    check("bad axis gone", f_empty, 1'b1);
    stop_test();
  end
endmodule : testbench
